// File: pslc_regs.vh
// Register offsets, field positions and reset values for the strap/LED block
`ifndef PSLC_REGS_VH
`define PSLC_REGS_VH

// ----------------------------------------------------------------------
// Register indices (word address = index, plain port)
// ----------------------------------------------------------------------
`define PSLC_REG_STATUS 5'h01
`define PSLC_REG_ADVERT 5'h04
`define PSLC_REG_CFG 5'h10
`define PSLC_REG_IRQ_CTRL 5'h11
`define PSLC_REG_STRAPS 5'h18
`define PSLC_REG_LED_LUT 5'h19
`define PSLC_REG_LINK_CTRL 5'h1A

// ----------------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------------
`define PSLC_CFG_REPEATER_STRAP_BIT 15
`define PSLC_CFG_IRQ_POL_BIT 14

// ----------------------------------------------------------------------
// Status and advertise capability bits
// ----------------------------------------------------------------------
`define PSLC_ST_100FD_BIT 14
`define PSLC_ST_100HD_BIT 13
`define PSLC_ST_10FD_BIT 12
`define PSLC_ST_10HD_BIT 11
`define PSLC_ST_ANEG_BIT 3
`define PSLC_AD_100FD_BIT 8
`define PSLC_AD_100HD_BIT 7
`define PSLC_AD_10FD_BIT 6
`define PSLC_AD_10HD_BIT 5

// ----------------------------------------------------------------------
// Interrupt control fields: enables in [15:8], pending in [7:0]
// ----------------------------------------------------------------------
`define PSLC_IRQ_EN_LSB 8
`define PSLC_IRQ_NUM 8

// ----------------------------------------------------------------------
// Link control fields
// ----------------------------------------------------------------------
`define PSLC_LC_ANEG_BIT 4
`define PSLC_LC_SPD100_BIT 3
`define PSLC_LC_FULL_BIT 2
`define PSLC_LC_MODE_LSB 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSLC_CFG_RST 16'h0000
`define PSLC_IRQ_RST 16'h0000
`define PSLC_LUT_RST 16'h6C93
`define PSLC_LC_RST 16'h001C

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSLC_REFCLK_DIV 4'h8
`define PSLC_BLINK_CYC 24'h98_9680

`endif

// File: pslc_strap_led.v
// Strap latch, LED drivers and interrupt pin of the 10/100 transceiver
`timescale 1ns/1ps
`default_nettype none
`include "pslc_regs.vh"

// Functional notes
// [RULE_01] Interrupt pin tri-state idle, polarity selectable
// [RULE_02] Interrupt event set chosen by software
// [RULE_03] Tech straps and negotiation latched at reset
// [RULE_04] Writes never exceed strapped capability ceiling
// [RULE_05] Negotiation strap low disables auto-negotiation
// [RULE_06] Repeater mode from strap or register bit
// [RULE_07] Repeater forces half duplex, no heartbeat
// [RULE_08] LED style strap low selects advanced
// [RULE_09] Receive LED toggles during receive activity
// [RULE_10] Scrambler strap low disables scrambler
// [RULE_11] Collision LED toggles in half duplex only
// [RULE_12] Link LED polarity depends on interface mode
// [RULE_13] Fiber strap low selects fiber operation
// [RULE_14] Fast speed LED low at 100 Mbps
// [RULE_15] Transmit LED toggles while transmitting
// [RULE_16] Clock strap low enables 25 MHz output
// [RULE_17] Slow speed LED low at 10 Mbps
// [RULE_18] Duplex LED low for full duplex
// [RULE_19] Advanced mode pairs pins into bi-colour LEDs
// [RULE_20] Bi-colour patterns held in writable table
module pslc_strap_led #(
  parameter BLINK_CYC = 24'h98_9680,
  parameter REFCLK_DIV = 4'h8
) (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // Register port
  input wire [4:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // Straps, sampled on the first clock after reset release
  input wire [2:0] tech_sel_strap_i,
  input wire autoneg_ability_strap_i,
  input wire repeater_strap_i,
  input wire led_style_strap_i,
  input wire scrambler_strap_i,
  input wire fiber_select_strap_i,
  input wire refclk_out_strap_i,
  // Link status from the datapath
  input wire link_up_i,
  input wire speed_100_i,
  input wire full_duplex_i,
  input wire rx_active_i,
  input wire tx_active_i,
  input wire collision_i,
  input wire serial_mode_i,
  input wire bypass_mode_i,
  input wire bypass_signal_detect_i,
  input wire [7:0] irq_event_i,
  // Configuration outputs
  output reg autoneg_enable_o,
  output reg scrambler_enable_o,
  output reg fiber_mode_o,
  output wire repeater_mode_o,
  output wire sqe_test_enable_o,
  output wire duplex_full_cfg_o,
  output wire speed_100_cfg_o,
  // LED pins
  output reg link_led_o,
  output reg rx_activity_led_o,
  output reg collision_led_o,
  output reg speed_fast_led_o,
  output reg tx_activity_led_o,
  output reg speed_slow_led_o,
  output reg duplex_led_o,
  // Reference clock out
  output reg refclk_out_o,
  // Interrupt pin
  output reg irq_out_o,
  output reg irq_out_oe_o
);

  // --------------------------------------------------------------------
  // Strap capture state
  // --------------------------------------------------------------------
  reg strap_done; // Straps taken after release
  reg [2:0] tech_sel; // Latched technology select
  reg aneg_cap; // Strapped negotiation ability
  reg repeater_strap_strap; // Latched repeater strap
  reg led_adv; // Advanced LED style
  reg clk_en; // Reference clock output enable
  reg cap_100fd; // Strapped capabilities
  reg cap_100hd;
  reg cap_10fd;
  reg cap_10hd;

  // --------------------------------------------------------------------
  // Software registers
  // --------------------------------------------------------------------
  reg [15:0] cfg; // Repeater and irq polarity
  reg [7:0] irq_en; // Event enables
  reg [7:0] irq_pend; // Sticky pending events
  reg [15:0] led_lut; // Bi-colour patterns
  reg lc_aneg; // Requested negotiation
  reg lc_spd100; // Requested speed
  reg lc_full; // Requested duplex
  reg [3:0] adv; // Advertised abilities

  // --------------------------------------------------------------------
  // Blink and divider state
  // --------------------------------------------------------------------
  reg [23:0] blink_cnt; // Blink period counter
  reg blink; // Blink phase
  reg [3:0] div_cnt; // Reference clock divider
  reg [7:0] next_pend; // Pending update

  // Clamp helper: request limited by strapped ability
  function clamp;
    input req;
    input cap;
    begin
      clamp = req & cap;
    end
  endfunction

  // Repeater mode and its effects
  assign repeater_mode_o = repeater_strap_strap | cfg[`PSLC_CFG_REPEATER_STRAP_BIT]; // RULE_06
  assign sqe_test_enable_o = ~repeater_mode_o; // RULE_07
  assign duplex_full_cfg_o = lc_full & ~repeater_mode_o; // RULE_07
  assign speed_100_cfg_o = lc_spd100;

  // --------------------------------------------------------------------
  // Strap capture on first clock after reset release
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_done <= 1'b0;
      tech_sel <= 3'h7;
      aneg_cap <= 1'b1;
      repeater_strap_strap <= 1'b0;
      led_adv <= 1'b0;
      clk_en <= 1'b0;
      autoneg_enable_o <= 1'b0;
      scrambler_enable_o <= 1'b1;
      fiber_mode_o <= 1'b0;
      cap_100fd <= 1'b0;
      cap_100hd <= 1'b0;
      cap_10fd <= 1'b0;
      cap_10hd <= 1'b0;
    end else if (!strap_done) begin
      // Latch every strap once
      strap_done <= 1'b1;
      tech_sel <= tech_sel_strap_i; // RULE_03
      aneg_cap <= autoneg_ability_strap_i; // RULE_03
      autoneg_enable_o <= autoneg_ability_strap_i; // RULE_05
      repeater_strap_strap <= repeater_strap_i; // RULE_06
      led_adv <= ~led_style_strap_i; // RULE_08
      scrambler_enable_o <= scrambler_strap_i; // RULE_10
      fiber_mode_o <= ~fiber_select_strap_i; // RULE_13
      clk_en <= ~refclk_out_strap_i; // RULE_16
      // Tech select: bit2 100M, bit1 10M (10M half also when bit2 low), bit0 full duplex allowed
      cap_100fd <= tech_sel_strap_i[2] & tech_sel_strap_i[0]; // RULE_03
      cap_100hd <= tech_sel_strap_i[2]; // RULE_03
      cap_10fd <= tech_sel_strap_i[1] & tech_sel_strap_i[0]; // RULE_03
      cap_10hd <= tech_sel_strap_i[1] | ~tech_sel_strap_i[2]; // RULE_03
    end else if (reg_wr_i && reg_addr_i == `PSLC_REG_LINK_CTRL) begin
      // Negotiation enable may drop, never exceed strap
      autoneg_enable_o <= clamp(reg_wdata_i[`PSLC_LC_ANEG_BIT],
        aneg_cap); // RULE_04
    end
  end

  // --------------------------------------------------------------------
  // Software register writes
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg <= `PSLC_CFG_RST;
      irq_en <= 8'h00;
      led_lut <= `PSLC_LUT_RST;
      lc_aneg <= 1'b1;
      lc_spd100 <= 1'b1;
      lc_full <= 1'b1;
      adv <= 4'hF;
    end else if (!strap_done) begin
      // Start at the strapped ceiling
      lc_aneg <= autoneg_ability_strap_i;
      lc_spd100 <= tech_sel_strap_i[2];
      lc_full <= tech_sel_strap_i[0];
      adv <= 4'hF;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `PSLC_REG_CFG: cfg <= reg_wdata_i; // RULE_06
        `PSLC_REG_IRQ_CTRL:
          irq_en <= reg_wdata_i[`PSLC_IRQ_EN_LSB +: `PSLC_IRQ_NUM]; // RULE_02
        `PSLC_REG_LED_LUT: led_lut <= reg_wdata_i; // RULE_20
        `PSLC_REG_ADVERT: begin
          adv <= {reg_wdata_i[`PSLC_AD_100FD_BIT],
            reg_wdata_i[`PSLC_AD_100HD_BIT],
            reg_wdata_i[`PSLC_AD_10FD_BIT],
            reg_wdata_i[`PSLC_AD_10HD_BIT]};
        end
        `PSLC_REG_LINK_CTRL: begin
          // Capability ceiling applied to each request
          lc_aneg <= clamp(reg_wdata_i[`PSLC_LC_ANEG_BIT], aneg_cap); // RULE_04
          lc_spd100 <= clamp(reg_wdata_i[`PSLC_LC_SPD100_BIT],
            cap_100hd); // RULE_04
          lc_full <= clamp(reg_wdata_i[`PSLC_LC_FULL_BIT],
            (cap_100fd | cap_10fd)); // RULE_04
        end
        default: cfg <= cfg;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Sticky interrupt pending; set beats clear
  // --------------------------------------------------------------------
  always @* begin
    next_pend = irq_pend;
    if (reg_wr_i && reg_addr_i == `PSLC_REG_IRQ_CTRL)
      next_pend = irq_pend & ~reg_wdata_i[`PSLC_IRQ_NUM-1:0];
    next_pend = next_pend | irq_event_i;
  end

  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_pend <= 8'h00;
      irq_out_o <= 1'b0;
      irq_out_oe_o <= 1'b0;
    end else begin
      irq_pend <= next_pend;
      // Drive only while an enabled event is pending
      irq_out_oe_o <= |(next_pend & irq_en); // RULE_02
      irq_out_o <= cfg[`PSLC_CFG_IRQ_POL_BIT]; // RULE_01
    end
  end

  // --------------------------------------------------------------------
  // Register read, data one cycle later
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `PSLC_REG_STATUS:
          reg_rdata_o <= {1'b0, cap_100fd, cap_100hd, cap_10fd, cap_10hd,
            7'h00, aneg_cap, link_up_i, 2'h0}; // RULE_03
        `PSLC_REG_ADVERT:
          reg_rdata_o <= {7'h00, adv[3] & cap_100fd, adv[2] & cap_100hd,
            adv[1] & cap_10fd, adv[0] & cap_10hd, 5'h01}; // RULE_04
        `PSLC_REG_CFG: reg_rdata_o <= cfg;
        `PSLC_REG_IRQ_CTRL: reg_rdata_o <= {irq_en, irq_pend};
        `PSLC_REG_STRAPS:
          reg_rdata_o <= {6'h00, tech_sel, aneg_cap, repeater_strap_strap, led_adv,
            scrambler_enable_o, fiber_mode_o, clk_en, repeater_mode_o};
        `PSLC_REG_LED_LUT: reg_rdata_o <= led_lut;
        `PSLC_REG_LINK_CTRL:
          reg_rdata_o <= {11'h000, lc_aneg, lc_spd100,
            duplex_full_cfg_o, 2'h0};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // --------------------------------------------------------------------
  // Blink timer and reference clock divider
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      blink_cnt <= 24'h00_0000;
      blink <= 1'b0;
      div_cnt <= 4'h0;
      refclk_out_o <= 1'b0;
    end else begin
      if (blink_cnt >= BLINK_CYC - 24'h00_0001) begin
        blink_cnt <= 24'h00_0000;
        blink <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 24'h00_0001;
      end
      // Free running 25 MHz output when enabled
      if (!clk_en) begin
        div_cnt <= 4'h0;
        refclk_out_o <= 1'b0; // RULE_16
      end else if (div_cnt >= (REFCLK_DIV >> 1) - 4'h1) begin
        div_cnt <= 4'h0;
        refclk_out_o <= ~refclk_out_o; // RULE_16
      end else begin
        div_cnt <= div_cnt + 4'h1;
      end
    end
  end

  // --------------------------------------------------------------------
  // LED drivers, outputs are active low unless noted
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_led_o <= 1'b1;
      rx_activity_led_o <= 1'b1;
      collision_led_o <= 1'b1;
      speed_fast_led_o <= 1'b1;
      tx_activity_led_o <= 1'b1;
      speed_slow_led_o <= 1'b1;
      duplex_led_o <= 1'b1;
    end else begin
      // Link: low in MII, high in serial, detect in bypass
      if (bypass_mode_i)
        link_led_o <= bypass_signal_detect_i; // RULE_12
      else if (serial_mode_i)
        link_led_o <= link_up_i; // RULE_12
      else
        link_led_o <= ~link_up_i; // RULE_12
      rx_activity_led_o <= rx_active_i ? blink : 1'b1; // RULE_09
      // Operating duplex decides; repeater mode counts as half
      collision_led_o <= (collision_i &&
        !(full_duplex_i & ~repeater_mode_o)) ? blink : 1'b1; // RULE_11
      if (!led_adv) begin
        speed_fast_led_o <= ~speed_100_i; // RULE_14
        speed_slow_led_o <= speed_100_i; // RULE_17
        tx_activity_led_o <= tx_active_i ? blink : 1'b1; // RULE_15
        duplex_led_o <= ~(full_duplex_i & ~repeater_mode_o); // RULE_18
      end else begin
        // Pair A: state {link, speed}; pair B: {link, duplex}
        speed_fast_led_o <= led_lut[{1'b0, link_up_i, speed_100_i,
          1'b0}]; // RULE_19
        tx_activity_led_o <= led_lut[{1'b0, link_up_i, speed_100_i,
          1'b1}]; // RULE_19
        speed_slow_led_o <= led_lut[{1'b1, link_up_i, full_duplex_i,
          1'b0}]; // RULE_20
        duplex_led_o <= led_lut[{1'b1, link_up_i, full_duplex_i,
          1'b1}]; // RULE_20
      end
    end
  end

endmodule // pslc_strap_led
`default_nettype wire

// File: pslc_strap_led_checker.sv
// Concurrent checks on the strap/LED block ports
`timescale 1ns/1ps
`default_nettype none
module pslc_strap_led_checker #(
  parameter BLINK_CYC = 24'h98_9680,
  parameter REFCLK_DIV = 4'h8
) (
  // Clock and reset
  input wire core_clk_i,
  input wire reset_n_i,
  // Straps and line status
  input wire autoneg_ability_strap_i,
  input wire led_style_strap_i,
  input wire scrambler_strap_i,
  input wire fiber_select_strap_i,
  input wire refclk_out_strap_i,
  input wire link_up_i,
  input wire speed_100_i,
  input wire full_duplex_i,
  input wire rx_active_i,
  input wire tx_active_i,
  input wire serial_mode_i,
  input wire bypass_mode_i,
  input wire bypass_signal_detect_i,
  // Outputs watched
  input wire autoneg_enable_o,
  input wire scrambler_enable_o,
  input wire fiber_mode_o,
  input wire repeater_mode_o,
  input wire sqe_test_enable_o,
  input wire duplex_full_cfg_o,
  input wire link_led_o,
  input wire rx_activity_led_o,
  input wire collision_led_o,
  input wire speed_fast_led_o,
  input wire tx_activity_led_o,
  input wire speed_slow_led_o,
  input wire duplex_led_o,
  input wire refclk_out_o,
  input wire irq_out_oe_o
);
  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  logic [1:0] up_cnt; // Edges since reset release, saturating
  logic rx_q; // Previous receive LED level
  logic tx_q; // Previous transmit LED level
  logic [15:0] rx_gap; // Active cycles without a receive LED change
  logic [15:0] tx_gap; // Active cycles without a transmit LED change
  wire settled = (up_cnt == 2'd3);
  // Track settle time and blink gaps
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      up_cnt <= 2'd0;
      rx_q <= 1'b1;
      tx_q <= 1'b1;
      rx_gap <= 16'h0000;
      tx_gap <= 16'h0000;
    end else begin
      up_cnt <= settled ? up_cnt : up_cnt + 2'd1;
      rx_q <= rx_activity_led_o;
      tx_q <= tx_activity_led_o;
      rx_gap <= (!rx_active_i || rx_q != rx_activity_led_o) ? 16'h0000
                : rx_gap + 16'h0001;
      tx_gap <= (!tx_active_i || tx_q != tx_activity_led_o) ? 16'h0000
                : tx_gap + 16'h0001;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_aneg_ceiling: assert property (
    settled && !autoneg_ability_strap_i |-> !autoneg_enable_o)
    else $error("negotiation enabled above strap");
  a_scram_strap: assert property (
    settled |-> scrambler_enable_o == scrambler_strap_i)
    else $error("scrambler enable differs from strap");
  a_fiber_strap: assert property (
    settled |-> fiber_mode_o == !fiber_select_strap_i)
    else $error("fiber mode differs from strap");
  a_repeater_strap_half: assert property (
    repeater_mode_o |-> !duplex_full_cfg_o && !sqe_test_enable_o)
    else $error("repeater mode not half duplex");
  a_link_led: assert property (
    (settled && link_up_i && !bypass_mode_i)[*2] ##0 $stable(serial_mode_i)
    |-> link_led_o == serial_mode_i)
    else $error("link led level wrong");
  a_bypass_sd: assert property (
    (settled && bypass_mode_i && bypass_signal_detect_i)[*2] |-> link_led_o)
    else $error("signal detect led not high");
  a_slow_speed: assert property (
    (settled && led_style_strap_i && link_up_i && !speed_100_i)[*2]
    |-> !speed_slow_led_o && speed_fast_led_o)
    else $error("speed leds wrong at 10M");
  a_fast_speed: assert property (
    (settled && led_style_strap_i && speed_100_i)[*2]
    |-> !speed_fast_led_o && speed_slow_led_o)
    else $error("speed leds wrong at 100M");
  a_duplex_led: assert property (
    (settled && led_style_strap_i && link_up_i
      && full_duplex_i == duplex_full_cfg_o)[*2] ##0 $stable(full_duplex_i)
    |-> duplex_led_o == !full_duplex_i)
    else $error("duplex led wrong");
  a_col_quiet: assert property (
    (settled && full_duplex_i && !repeater_mode_o)[*8] |-> collision_led_o)
    else $error("collision led active in full duplex");
  a_refclk_runs: assert property (
    settled && !refclk_out_strap_i && $changed(refclk_out_o)
    |=> $stable(refclk_out_o)[*3] ##1 $changed(refclk_out_o))
    else $error("reference clock period wrong");
  a_refclk_off: assert property (
    settled && refclk_out_strap_i |-> !refclk_out_o)
    else $error("reference clock running while disabled");
  a_rx_blink: assert property (rx_gap <= 2 * BLINK_CYC + 4)
    else $error("receive led not toggling");
  a_tx_blink: assert property (
    led_style_strap_i |-> tx_gap <= 2 * BLINK_CYC + 4)
    else $error("transmit led not toggling");

  // Main scenarios reached
  c_rx_seen: cover property (rx_active_i ##1 $changed(rx_activity_led_o));
  c_irq_drive: cover property ($rose(irq_out_oe_o));
  c_repeater: cover property (repeater_mode_o);
endmodule // pslc_strap_led_checker
`default_nettype wire

// File: pslc_mac_model.sv
// Far-side model: MAC and line status feeding the block
`timescale 1ns/1ps
`default_nettype none
module pslc_mac_model (
  // Clock and scenario select
  input wire logic core_clk_i,
  input wire logic [2:0] mode_i,
  // Line status toward the block
  output logic [8:0] status_o
);
  // Status vector: link, 100M, full, rx, tx, col, serial, bypass, detect
  logic [8:0] st = 9'h000;
  assign status_o = st;
  // Line state follows the selected scenario one edge later
  always @(posedge core_clk_i) begin
    case (mode_i)
      3'd1: st <= 9'b100100000; // 10M half link, receiving
      3'd2: st <= 9'b101011000; // 10M full link, sending, wire collision
      3'd3: st <= 9'b100001000; // 10M half link with collision
      3'd4: st <= 9'b100000100; // Serial interface link
      3'd5: st <= 9'b000000011; // Symbol bypass with signal detect
      3'd6: st <= 9'b111000000; // 100M full link, idle
      default: st <= 9'b000000000; // No link
    endcase
  end
endmodule // pslc_mac_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the strap/LED block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [4:0] reg_addr_i = 5'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] irq_ev = 8'h00;
  logic [2:0] mode = 3'd0;
  logic [8:0] straps = 9'h0CA; // tech[8:6],aneg,repeater_strap,led,scram,fiber,ref
  logic [8:0] st;
  wire [15:0] rdata;
  wire [9:0] pins; // link,rx,col,fast,tx,slow,dpx,ref,irq,oe
  wire [6:0] cfg; // aneg,scram,fiber,repeater,sqe,full,100
  logic [15:0] rd_val;
  logic prev;
  integer n;
  integer error_cnt = 0;
  integer checked = 0;

  // Clock at 200 MHz
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  pslc_mac_model mac_u (.core_clk_i(core_clk_i), .mode_i(mode),
    .status_o(st));

  pslc_strap_led #(.BLINK_CYC(24'h00_0004), .REFCLK_DIV(4'h8)) dut_u (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
    .tech_sel_strap_i(straps[8:6]), .autoneg_ability_strap_i(straps[5]),
    .repeater_strap_i(straps[4]), .led_style_strap_i(straps[3]),
    .scrambler_strap_i(straps[2]), .fiber_select_strap_i(straps[1]),
    .refclk_out_strap_i(straps[0]),
    .link_up_i(st[8]), .speed_100_i(st[7]), .full_duplex_i(st[6]),
    .rx_active_i(st[5]), .tx_active_i(st[4]), .collision_i(st[3]),
    .serial_mode_i(st[2]), .bypass_mode_i(st[1]),
    .bypass_signal_detect_i(st[0]), .irq_event_i(irq_ev),
    .autoneg_enable_o(cfg[6]), .scrambler_enable_o(cfg[5]),
    .fiber_mode_o(cfg[4]), .repeater_mode_o(cfg[3]),
    .sqe_test_enable_o(cfg[2]), .duplex_full_cfg_o(cfg[1]),
    .speed_100_cfg_o(cfg[0]),
    .link_led_o(pins[9]), .rx_activity_led_o(pins[8]),
    .collision_led_o(pins[7]), .speed_fast_led_o(pins[6]),
    .tx_activity_led_o(pins[5]), .speed_slow_led_o(pins[4]),
    .duplex_led_o(pins[3]), .refclk_out_o(pins[2]),
    .irq_out_o(pins[1]), .irq_out_oe_o(pins[0]));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task reg_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task reg_rd(input logic [4:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = rdata;
  endtask
  task pulse_ev(input logic [7:0] v);
    @(posedge core_clk_i);
    irq_ev <= v;
    @(posedge core_clk_i);
    irq_ev <= 8'h00;
    #1;
  endtask
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog far beyond the expected few microseconds
  initial begin
    #50000;
    error_cnt = error_cnt + 1;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 check({13'h0000, cfg[6:4]}, 16'h0000);
    reg_rd(5'h01);
    check(rd_val, 16'h1800);
    reg_rd(5'h04);
    check(rd_val, 16'h0061);
    reg_wr(5'h1A, 16'h001C);
    reg_rd(5'h1A);
    check(rd_val, 16'h0004);
    check({15'h0000, cfg[0]}, 16'h0000);
    reg_rd(5'h05);
    check(rd_val, 16'h0000);
    // Repeater mode by software
    reg_wr(5'h10, 16'h8000);
    reg_rd(5'h10);
    check(rd_val, 16'h8000);
    check({13'h0000, cfg[3:1]}, 16'h0004);
    reg_wr(5'h10, 16'h4000);
    // Interrupt pin, active high
    check({15'h0000, pins[0]}, 16'h0000);
    reg_wr(5'h11, 16'h0100);
    pulse_ev(8'h01);
    check({14'h0000, pins[1:0]}, 16'h0003);
    reg_rd(5'h11);
    check(rd_val, 16'h0101);
    reg_wr(5'h11, 16'h0101);
    repeat (2) @(posedge core_clk_i);
    #1 check({15'h0000, pins[0]}, 16'h0000);
    pulse_ev(8'h02);
    check({15'h0000, pins[0]}, 16'h0000);
    reg_rd(5'h11);
    check(rd_val, 16'h0102);
    reg_wr(5'h11, 16'h0102);
    reg_wr(5'h10, 16'h0000);
    // Interrupt pin, active low
    pulse_ev(8'h01);
    check({14'h0000, pins[1:0]}, 16'h0001);
    reg_wr(5'h11, 16'h0001);
    // Line scenarios, link LED level per mode
    for (n = 1; n < 7; n = n + 1) begin
      mode <= n[2:0];
      repeat (40) @(posedge core_clk_i);
      #1 check({15'h0000, pins[9]}, {15'h0000, n == 4 || n == 5});
      if (n == 6)
        check({14'h0000, pins[6], pins[4]}, 16'h0001);
      if (n == 1)
        check({13'h0000, pins[4:3], pins[6]}, 16'h0003);
      if (n == 2)
        check({14'h0000, pins[7], pins[3]}, 16'h0002);
    end
    // Collision LED blinks in half duplex
    mode <= 3'd3;
    repeat (4) @(posedge core_clk_i);
    n = 0;
    prev = pins[7];
    repeat (24) begin
      @(posedge core_clk_i);
      #1 if (pins[7] !== prev) n = n + 1;
      prev = pins[7];
    end
    check({15'h0000, n > 0}, 16'h0001);
    // Second reset with every strap except tech select bit 1 at its other level
    reset_n_i <= 1'b0;
    straps <= 9'h1B5;
    mode <= 3'd6;
    repeat (20) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 check({12'h000, cfg[6:3]}, 16'h000F);
    check({14'h0000, cfg[2:1]}, 16'h0000);
    reg_rd(5'h01);
    check(rd_val, 16'h280C);
    reg_rd(5'h04);
    check(rd_val, 16'h00A1);
    reg_rd(5'h18);
    check(rd_val, 16'h037D);
    reg_wr(5'h1A, 16'h001C);
    reg_rd(5'h1A);
    check(rd_val, 16'h0018);
    check({15'h0000, cfg[0]}, 16'h0001);
    // Advanced LEDs follow the table: reset pattern, then a new one
    check({12'h000, pins[6:3]}, 16'h0006);
    reg_wr(5'h19, 16'hFF3F);
    repeat (2) @(posedge core_clk_i);
    #1 check({12'h000, pins[6:3]}, 16'h0003);
    check({15'h0000, pins[2]}, 16'h0000);
    complete_run();
  end
endmodule // testbench

bind pslc_strap_led pslc_strap_led_checker #(.BLINK_CYC(BLINK_CYC),
  .REFCLK_DIV(REFCLK_DIV)) chk_u (.core_clk_i, .reset_n_i,
  .autoneg_ability_strap_i, .led_style_strap_i, .scrambler_strap_i,
  .fiber_select_strap_i, .refclk_out_strap_i, .link_up_i, .speed_100_i,
  .full_duplex_i, .rx_active_i, .tx_active_i, .serial_mode_i,
  .bypass_mode_i, .bypass_signal_detect_i, .autoneg_enable_o,
  .scrambler_enable_o, .fiber_mode_o, .repeater_mode_o, .sqe_test_enable_o,
  .duplex_full_cfg_o, .link_led_o, .rx_activity_led_o, .collision_led_o,
  .speed_fast_led_o, .tx_activity_led_o, .speed_slow_led_o, .duplex_led_o,
  .refclk_out_o, .irq_out_oe_o);
`default_nettype wire
